/* hdl/pbrs_pkg.sv */
// Constants and types of the buffered-register sync block.
// Assumes a single system clock and software-driven control ports.
//
// Functional notes
// R1: With no counter clock selected, value writes take effect at once.
// R2: Legacy output compare loads a written channel value at next counter change.
// R3: Legacy edge-aligned loads channel value at counter wrap to start value.
// R4: Legacy center-aligned loads channel value when counter turns down from limit.
// R5: Enhanced output compare loads at next change, or by pair sync if enabled.
// R6: Enhanced other modes with pair sync update channel values only by sync.
// R7: Sync transfers buffered values and can force counter to start value.
// R8: Software uses sync only in combine mode and prefers enhanced scheme.
// R9: Three enabled hardware triggers start sync on a detected rising edge.
// R10: Clear mode 0 clears an enable on write 0 or own event; write wins.
// R11: Clear mode 1 clears an enable only on write 0; enhanced scheme only; code applies mode 1 in either scheme.
// R12: Writing 1 requests software sync; clears on write 0 or completion.
// R13: A new request at completion starts another sync; bit stays 1.
// R14: Legacy request clears at loading point, or at event when restart set; code clears at event only with select 0.
// R15: Enhanced request clears at loading point, or at event with counter reset.
// R16: Boundary is wrap in up counting, each reversal in up-down counting.
// R17: Boundaries load only where min or max loading-point bits select them.
// R18: Period limit sync works only while enhanced features are enabled.
// R19: Legacy select 0, restart 0: period loads at loading point after trigger.
// R20: Legacy select 0, restart 1: period loads on the trigger event itself.
// R21: Legacy select 1: period loads at loading point after software trigger.
// R22: Start value sync needs enhanced features, enhanced scheme and its enable.
// R23: Enhanced sync loads at loading point with buffer bit, at once with reset.
// R24: Hardware triggers pass a two-flop synchroniser and edge detector.
package pbrs_pkg;
    localparam int PBRS_W = 16;
    localparam int PBRS_NCH = 2;
    localparam int PBRS_NTRIG = 3;
    localparam int PBRS_VAL_RST = 0;
    localparam logic [1:0] PBRS_CLK_NONE = 2'h0;
    localparam logic PBRS_SCHEME_LEGACY = 1'h0;
    localparam logic PBRS_CLEAR_ON_EVENT = 1'h0;
    typedef enum logic [1:0] {
        PBRS_OC,
        PBRS_EDGE_ALIGNED_PWM,
        PBRS_CENTER_ALIGNED_PWM
    } pbrs_mode_t;
endpackage

/* hdl/pbrs_trig_if.sv */
// Trigger pulses from the synchroniser to the sync logic.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface pbrs_trig_if #(parameter int N = 3);
    logic [N-1:0] rise;
    modport src (output rise);
    modport snk (input rise);
endinterface

/* hdl/pbrs_trig_sync.sv */
// Hardware trigger synchroniser and rising edge detector.
// Assumes trigger inputs may be asynchronous to the system clock.
`timescale 1ns/10ps
module pbrs_trig_sync #(
    parameter int N = pbrs_pkg::PBRS_NTRIG
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Raw triggers
    input wire logic [N-1:0] i_hw_trigger,
    // Edge pulses
    pbrs_trig_if.src trig
);
    import pbrs_pkg::*;

    logic [N-1:0] meta_ff, sync_ff, prev_ff;
    logic [N-1:0] nxt_meta, nxt_sync, nxt_prev;

    always_comb begin
        nxt_meta = i_hw_trigger;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // Two-flop synchroniser, then edge history [R24]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // One-cycle pulse per rising edge [R9] [R24]
    assign trig.rise = sync_ff & ~prev_ff;

    property p_rise_single;
        @(posedge i_clk) disable iff (!i_rstn)
        trig.rise[0] |=> !trig.rise[0];
    endproperty
    a_rise_single: assert property (p_rise_single) // [R24]
        else $error("trigger pulse longer than one cycle");
endmodule

/* hdl/pbrs_sync.sv */
// Buffered-register update and PWM synchronisation of a timer channel pair.
// Assumes the counter block reports tick, wrap and reversal events.
`timescale 1ns/10ps
module pbrs_sync #(
    parameter int W = pbrs_pkg::PBRS_W,
    parameter int NCH = pbrs_pkg::PBRS_NCH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Configuration
    input wire logic [1:0] i_clock_source_select,
    input wire logic i_enhanced_features_enable,
    input wire logic i_sync_scheme_select,
    input wire logic i_hw_trigger_clear_mode,
    input wire logic i_legacy_trigger_select,
    input wire logic i_counter_restart_on_sync,
    input wire logic i_sw_counter_reset_sync,
    input wire logic i_hw_counter_reset_sync,
    input wire logic i_sw_buffer_load,
    input wire logic i_hw_buffer_load,
    input wire logic i_pair_buffer_sync_enable,
    input wire logic i_min_loading_point,
    input wire logic i_max_loading_point,
    input wire logic i_start_value_sync_enable,
    input wire pbrs_pkg::pbrs_mode_t i_pwm_mode,
    // Counter events
    input wire logic i_cnt_tick,
    input wire logic i_cnt_up_down,
    input wire logic i_cnt_wrap,
    input wire logic i_cnt_top_turn,
    input wire logic i_cnt_bottom_turn,
    // Hardware triggers
    input wire logic [pbrs_pkg::PBRS_NTRIG-1:0] i_hw_trigger,
    // Software writes
    input wire logic i_trig_en_wr,
    input wire logic [pbrs_pkg::PBRS_NTRIG-1:0] i_trig_en_wdata,
    input wire logic i_sw_sync_wr,
    input wire logic i_sw_sync_wdata,
    input wire logic i_period_wr,
    input wire logic [W-1:0] i_period_wdata,
    input wire logic i_start_wr,
    input wire logic [W-1:0] i_start_wdata,
    input wire logic [NCH-1:0] i_chan_wr,
    input wire logic [W-1:0] i_chan_wdata,
    // Active values
    output logic [W-1:0] o_period_limit_value,
    output logic [W-1:0] o_counter_start_value,
    output logic [NCH-1:0][W-1:0] o_channel_compare_value,
    // Status
    output logic [pbrs_pkg::PBRS_NTRIG-1:0] o_hw_trigger_enable,
    output logic o_software_sync_request,
    // Strobes
    output logic o_loading_point,
    output logic o_sync_load,
    output logic o_counter_counter_restart_on_sync
);
    import pbrs_pkg::*;

    localparam int NT = PBRS_NTRIG;

    // Mode-dependent legacy update point
    function automatic logic legacy_point(input pbrs_mode_t m,
                                          input logic for_chan,
                                          input logic tick,
                                          input logic wrap,
                                          input logic top);
        logic r;
        case (m)
            PBRS_CENTER_ALIGNED_PWM: r = top;
            PBRS_EDGE_ALIGNED_PWM: r = wrap;
            PBRS_OC: r = for_chan ? tick : wrap;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    pbrs_trig_if #(.N(NT)) trig ();

    pbrs_trig_sync #(.N(NT)) u_trig (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_hw_trigger(i_hw_trigger),
        .trig(trig)
    );

    logic clk_on, leg, enh, lp, sw_ev, sw_imm, sw_lp_load;
    logic hw_imm, hw_arm, hw_any, sw_done, sync_now, sync_lp, hw_pend_ff;
    logic sync_load, counter_restart_on_sync, start_sync_ok, chan_sync_ok, chan_pt;
    logic [NT-1:0] trig_en_eff, hw_ev;

    always_comb begin
        clk_on = i_clock_source_select != PBRS_CLK_NONE;
        leg = i_sync_scheme_select == PBRS_SCHEME_LEGACY;
        enh = i_enhanced_features_enable;
        // Boundary cycles filtered by loading-point select [R16] [R17]
        if (i_cnt_up_down) begin
            lp = (i_max_loading_point & i_cnt_top_turn) |
                 (i_min_loading_point & i_cnt_bottom_turn);
        end else begin
            lp = (i_min_loading_point | i_max_loading_point) & i_cnt_wrap;
        end
        // A setting write enables the trigger in the same cycle [R10]
        trig_en_eff = o_hw_trigger_enable |
                      ({NT{i_trig_en_wr}} & i_trig_en_wdata);
        hw_ev = trig.rise & trig_en_eff; // [R9]
        hw_any = |hw_ev;
        sw_ev = i_sw_sync_wr & i_sw_sync_wdata; // [R12]
        // Immediate or deferred handling per scheme [R14] [R15]
        if (leg) begin
            sw_imm = !i_legacy_trigger_select & i_counter_restart_on_sync;
            hw_imm = sw_imm;
            hw_arm = !i_legacy_trigger_select & !i_counter_restart_on_sync;
            sw_lp_load = 1'b1;
        end else begin
            sw_imm = i_sw_counter_reset_sync;
            hw_imm = i_hw_counter_reset_sync;
            hw_arm = i_hw_buffer_load & !i_hw_counter_reset_sync;
            sw_lp_load = i_sw_buffer_load;
        end
        sw_done = lp & o_software_sync_request;
        // Load at once on event, or at the next loading point [R19]
        // [R20] [R21] [R23]
        sync_now = (sw_ev & sw_imm) | (hw_any & hw_imm);
        sync_lp = (sw_done & sw_lp_load) | (lp & hw_pend_ff);
        sync_load = clk_on & (sync_now | sync_lp); // [R7]
        // Counter restart, including hardware-only legacy select 1 [R7]
        counter_restart_on_sync = (sw_ev & sw_imm) |
                 (hw_any & (hw_imm | (leg & i_legacy_trigger_select &
                                     i_counter_restart_on_sync)));
        start_sync_ok = enh & !leg & i_start_value_sync_enable; // [R22]
        chan_sync_ok = enh & i_pair_buffer_sync_enable; // [R5] [R6]
        chan_pt = enh ? i_cnt_tick :
            legacy_point(i_pwm_mode, 1'b1, i_cnt_tick, i_cnt_wrap,
                         i_cnt_top_turn); // [R2] [R3] [R4] [R5]
    end

    assign o_loading_point = lp;
    assign o_sync_load = sync_load;
    assign o_counter_counter_restart_on_sync = clk_on & counter_restart_on_sync;

    // Trigger enables, software request, pending hardware sync
    logic [NT-1:0] nxt_trig_en;
    logic nxt_software_sync_request, nxt_hw_pend;

    always_comb begin
        nxt_trig_en = o_hw_trigger_enable;
        for (int n = 0; n < NT; n++) begin
            if (i_trig_en_wr) begin
                nxt_trig_en[n] = i_trig_en_wdata[n]; // [R10] [R11]
            end else if (i_hw_trigger_clear_mode == PBRS_CLEAR_ON_EVENT &&
                         hw_ev[n]) begin
                nxt_trig_en[n] = 1'b0; // [R10]
            end
        end
        nxt_software_sync_request = o_software_sync_request;
        if (sw_done) begin
            nxt_software_sync_request = 1'b0; // [R12] [R14] [R15]
        end
        // New request beats completion; immediate modes clear on event
        if (i_sw_sync_wr) begin
            nxt_software_sync_request = i_sw_sync_wdata & !sw_imm; // [R13] [R14] [R15]
        end
        nxt_hw_pend = hw_pend_ff;
        if (lp) begin
            nxt_hw_pend = 1'b0;
        end
        if (hw_any & hw_arm) begin
            nxt_hw_pend = 1'b1; // [R19]
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hw_trigger_enable <= '0;
            o_software_sync_request <= 1'b0;
            hw_pend_ff <= 1'b0;
        end else begin
            o_hw_trigger_enable <= nxt_trig_en;
            o_software_sync_request <= nxt_software_sync_request;
            hw_pend_ff <= nxt_hw_pend;
        end
    end

    // Buffers and active values
    logic [W-1:0] period_buf_ff, start_buf_ff;
    logic [W-1:0] nxt_period_buf, nxt_start_buf, nxt_period, nxt_start;
    logic [NCH-1:0][W-1:0] chan_buf_ff, nxt_chan_buf, nxt_chan;
    logic period_dirty_ff, start_dirty_ff, nxt_period_dirty;
    logic nxt_start_dirty;
    logic [NCH-1:0] chan_dirty_ff, nxt_chan_dirty;

    always_comb begin
        nxt_period = o_period_limit_value;
        nxt_period_buf = period_buf_ff;
        nxt_period_dirty = period_dirty_ff;
        if (!clk_on) begin
            nxt_period_dirty = 1'b0;
            if (i_period_wr) begin
                nxt_period = i_period_wdata; // [R1]
            end
        end else if (!enh) begin
            if (period_dirty_ff &&
                legacy_point(i_pwm_mode, 1'b0, i_cnt_tick, i_cnt_wrap,
                             i_cnt_top_turn)) begin
                nxt_period = period_buf_ff;
                nxt_period_dirty = 1'b0;
            end
        end else if (sync_load) begin
            nxt_period = period_buf_ff; // [R18] [R19] [R20] [R21]
            nxt_period_dirty = 1'b0;
        end
        if (i_period_wr) begin
            nxt_period_buf = i_period_wdata;
            nxt_period_dirty = clk_on;
        end

        nxt_start = o_counter_start_value;
        nxt_start_buf = start_buf_ff;
        nxt_start_dirty = start_dirty_ff;
        if (!clk_on) begin
            nxt_start_dirty = 1'b0;
            if (i_start_wr) begin
                nxt_start = i_start_wdata; // [R1]
            end
        end else if (!enh || !i_start_value_sync_enable) begin
            if (start_dirty_ff) begin
                nxt_start = start_buf_ff;
                nxt_start_dirty = 1'b0;
            end
        end else if (start_sync_ok && sync_load) begin
            nxt_start = start_buf_ff; // [R22] [R23]
            nxt_start_dirty = 1'b0;
        end
        if (i_start_wr) begin
            nxt_start_buf = i_start_wdata;
            nxt_start_dirty = clk_on;
        end

        nxt_chan = o_channel_compare_value;
        nxt_chan_buf = chan_buf_ff;
        nxt_chan_dirty = chan_dirty_ff;
        for (int c = 0; c < NCH; c++) begin
            if (!clk_on) begin
                nxt_chan_dirty[c] = 1'b0;
                if (i_chan_wr[c]) begin
                    nxt_chan[c] = i_chan_wdata; // [R1]
                end
            end else if (chan_sync_ok) begin
                if (sync_load) begin
                    nxt_chan[c] = chan_buf_ff[c]; // [R5] [R6] [R23]
                    nxt_chan_dirty[c] = 1'b0;
                end
            end else if (chan_dirty_ff[c] && chan_pt) begin
                nxt_chan[c] = chan_buf_ff[c]; // [R2] [R3] [R4] [R5]
                nxt_chan_dirty[c] = 1'b0;
            end
            if (i_chan_wr[c]) begin
                nxt_chan_buf[c] = i_chan_wdata;
                nxt_chan_dirty[c] = clk_on;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_period_limit_value <= W'(PBRS_VAL_RST);
            o_counter_start_value <= W'(PBRS_VAL_RST);
            o_channel_compare_value <= '0;
            period_buf_ff <= W'(PBRS_VAL_RST);
            start_buf_ff <= W'(PBRS_VAL_RST);
            chan_buf_ff <= '0;
            period_dirty_ff <= 1'b0;
            start_dirty_ff <= 1'b0;
            chan_dirty_ff <= '0;
        end else begin
            o_period_limit_value <= nxt_period;
            o_counter_start_value <= nxt_start;
            o_channel_compare_value <= nxt_chan;
            period_buf_ff <= nxt_period_buf;
            start_buf_ff <= nxt_start_buf;
            chan_buf_ff <= nxt_chan_buf;
            period_dirty_ff <= nxt_period_dirty;
            start_dirty_ff <= nxt_start_dirty;
            chan_dirty_ff <= nxt_chan_dirty;
        end
    end

    property p_clk_off_period;
        @(posedge i_clk) disable iff (!i_rstn)
        (!clk_on && i_period_wr) |=>
            o_period_limit_value == $past(i_period_wdata);
    endproperty
    a_clk_off_period: assert property (p_clk_off_period) // [R1]
        else $error("period not written at once with clock off");

    property p_legacy_oc_chan;
        @(posedge i_clk) disable iff (!i_rstn)
        (clk_on && !enh && i_pwm_mode == PBRS_OC && i_cnt_tick &&
         chan_dirty_ff[1] && !i_chan_wr[1]) |=>
            o_channel_compare_value[1] == $past(chan_buf_ff[1]);
    endproperty
    a_legacy_oc_chan: assert property (p_legacy_oc_chan) // [R2]
        else $error("channel value missed counter change");

    property p_pair_sync_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (clk_on && chan_sync_ok && !sync_load) |=>
            $stable(o_channel_compare_value);
    endproperty
    a_pair_sync_hold: assert property (p_pair_sync_hold) // [R6]
        else $error("channel value changed outside pair sync");

    property p_trig_clear_event;
        @(posedge i_clk) disable iff (!i_rstn)
        (hw_ev[0] && !i_trig_en_wr &&
         i_hw_trigger_clear_mode == PBRS_CLEAR_ON_EVENT) |=>
            !o_hw_trigger_enable[0];
    endproperty
    a_trig_clear_event: assert property (p_trig_clear_event) // [R10]
        else $error("trigger enable not cleared by its event");

    property p_trig_hold_mode1;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_hw_trigger_clear_mode && !i_trig_en_wr &&
         o_hw_trigger_enable[0]) |=> o_hw_trigger_enable[0];
    endproperty
    a_trig_hold_mode1: assert property (p_trig_hold_mode1) // [R11]
        else $error("trigger enable cleared without write in mode 1");

    property p_sw_retrigger;
        @(posedge i_clk) disable iff (!i_rstn)
        (sw_done && sw_ev && !sw_imm) |=> o_software_sync_request;
    endproperty
    a_sw_retrigger: assert property (p_sw_retrigger) // [R13]
        else $error("request lost at completion");

    property p_enh_reset_now;
        @(posedge i_clk) disable iff (!i_rstn)
        (clk_on && !leg && i_sw_counter_reset_sync && sw_ev) |->
            o_counter_counter_restart_on_sync && o_sync_load ##1 !o_software_sync_request;
    endproperty
    a_enh_reset_now: assert property (p_enh_reset_now) // [R15]
        else $error("counter reset sync not immediate");

    property p_no_lp_unselected;
        @(posedge i_clk) disable iff (!i_rstn)
        (!i_min_loading_point && !i_max_loading_point) |-> !o_loading_point;
    endproperty
    a_no_lp_unselected: assert property (p_no_lp_unselected) // [R17]
        else $error("loading point without selection");

    property p_period_needs_enh;
        @(posedge i_clk) disable iff (!i_rstn)
        (clk_on && !enh && !period_dirty_ff) |=>
            $stable(o_period_limit_value);
    endproperty
    a_period_needs_enh: assert property (p_period_needs_enh) // [R18]
        else $error("period loaded by sync without enhanced features");
endmodule

/* verification/pbrs_trig_src.sv */
// Model of the on-chip hardware trigger sources.
// Assumes the bench pulses i_fire for one clock per trigger wanted.
`timescale 1ns/10ps
module pbrs_trig_src (
    // Clock
    input wire logic i_clk,
    // Requests from the bench
    input wire logic [2:0] i_fire,
    // Trigger levels
    output logic [2:0] o_trig
);
    // Starts idle; first edge also drives the level low
    logic [2:0] cnt_ff = 3'h0;
    // Level held for several clocks so the synchroniser sees it
    always @(posedge i_clk) begin
        if (i_fire != 3'h0) begin
            o_trig <= o_trig | i_fire;
            cnt_ff <= 3'h5;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end else begin
            o_trig <= 3'h0;
        end
    end
endmodule

/* verification/tb.sv */
// Self-checking bench of the buffered-register sync block.
// Assumes one 250 MHz clock; bench plays software and counter events.
`timescale 1ns/10ps
module tb;
    import pbrs_pkg::*;
    logic clk, rstn, up_down, max_lp, min_lp, enh, scheme, clr_mode;
    logic sel, restart, sw_rst, hw_rst, sw_buf, hw_buf, pair, st_en;
    logic per_wr, st_wr, sw_wr, ten_wr, rein;
    logic [1:0] clk_sel, chan_wr;
    logic [2:0] fire, trig, ten;
    logic [3:0] evb;
    logic [15:0] wd, per, st;
    logic [1:0][15:0] chv;
    logic req, lp, sload, counter_restart_on_sync;
    logic [1:0] evs;
    pbrs_mode_t mode;
    int fails = 0;
    int checks = 0;

    pbrs_trig_src u_pbrs_trig_src (.i_clk(clk), .i_fire(fire),
        .o_trig(trig));
    pbrs_sync u_pbrs_sync (.i_clk(clk), .i_rstn(rstn),
        .i_clock_source_select(clk_sel), .i_enhanced_features_enable(enh),
        .i_sync_scheme_select(scheme), .i_hw_trigger_clear_mode(clr_mode),
        .i_legacy_trigger_select(sel), .i_counter_restart_on_sync(restart),
        .i_sw_counter_reset_sync(sw_rst), .i_hw_counter_reset_sync(hw_rst),
        .i_sw_buffer_load(sw_buf), .i_hw_buffer_load(hw_buf),
        .i_pair_buffer_sync_enable(pair), .i_min_loading_point(min_lp),
        .i_max_loading_point(max_lp), .i_start_value_sync_enable(st_en),
        .i_pwm_mode(mode), .i_cnt_tick(evb[0]), .i_cnt_up_down(up_down),
        .i_cnt_wrap(evb[1]), .i_cnt_top_turn(evb[2]),
        .i_cnt_bottom_turn(evb[3]), .i_hw_trigger(trig),
        .i_trig_en_wr(ten_wr), .i_trig_en_wdata(wd[2:0]),
        .i_sw_sync_wr(sw_wr), .i_sw_sync_wdata(wd[0]),
        .i_period_wr(per_wr), .i_period_wdata(wd), .i_start_wr(st_wr),
        .i_start_wdata(wd), .i_chan_wr(chan_wr), .i_chan_wdata(wd),
        .o_period_limit_value(per), .o_counter_start_value(st),
        .o_channel_compare_value(chv), .o_hw_trigger_enable(ten),
        .o_software_sync_request(req), .o_loading_point(lp),
        .o_sync_load(sload), .o_counter_counter_restart_on_sync(counter_restart_on_sync));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic cv(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic cb(input logic [2:0] g, input logic [2:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t bits %b expected %b", $time, g, e);
        end
    endtask

    // Kind: 0/1 channel, 2 period, 3 start, 4 sw request, 5 enables
    task automatic wr(input int k, input logic [15:0] d,
                      input logic [3:0] e = 4'h0);
        @(posedge clk);
        #1;
        wd = d;
        evb = e;
        case (k)
            0, 1: chan_wr[k%2] = 1'b1;
            2: per_wr = 1'b1;
            3: st_wr = 1'b1;
            4: sw_wr = 1'b1;
            default: ten_wr = 1'b1;
        endcase
        #1 rein = counter_restart_on_sync;
        @(posedge clk);
        #1;
        chan_wr = 2'h0;
        {per_wr, st_wr, sw_wr, ten_wr} = 4'h0;
        evb = 4'h0;
    endtask

    task automatic ev(input int k);
        @(posedge clk);
        #1;
        evb[k] = 1'b1;
        #1 evs = {lp, sload};
        @(posedge clk);
        #1;
        evb = 4'h0;
    endtask

    task automatic shot(input logic [2:0] f);
        @(posedge clk);
        #1;
        fire = f;
        @(posedge clk);
        #1;
        fire = 3'h0;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        stop_test;
    end

    initial begin
        rstn = 1'b0;
        {up_down, max_lp, min_lp, enh, scheme, clr_mode} = 6'h0;
        {sel, restart, sw_rst, hw_rst, sw_buf, hw_buf, pair, st_en} = 8'h0;
        {per_wr, st_wr, sw_wr, ten_wr, rein} = 5'h0;
        clk_sel = 2'h0;
        chan_wr = 2'h0;
        fire = 3'h0;
        evb = 4'h0;
        wd = 16'h0000;
        mode = PBRS_OC;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        cv(per, 16'h0000);
        cb(ten, 3'h0);
        wr(0, 16'h1234);
        cv(chv[0], 16'h1234);
        wr(2, 16'h0055);
        cv(per, 16'h0055);
        done("clock_off");
        clk_sel = 2'h1;
        wr(1, 16'h0A5A);
        cv(chv[1], 16'h0000);
        ev(0);
        cv(chv[1], 16'h0A5A);
        mode = PBRS_EDGE_ALIGNED_PWM;
        wr(0, 16'h5555);
        wr(2, 16'h00FF);
        ev(0);
        cv(chv[0], 16'h1234);
        cv(per, 16'h0055);
        ev(1);
        cv(chv[0], 16'h5555);
        cv(per, 16'h00FF);
        mode = PBRS_CENTER_ALIGNED_PWM;
        wr(1, 16'h7777);
        ev(1);
        cv(chv[1], 16'h0A5A);
        ev(2);
        cv(chv[1], 16'h7777);
        done("legacy_modes");
        mode = PBRS_EDGE_ALIGNED_PWM;
        {enh, scheme, sw_buf} = 3'h7;
        wr(2, 16'h0100);
        wr(4, 16'h0001);
        cb({2'h0, req}, 3'h1);
        ev(1);
        cv(per, 16'h00FF);
        cb({1'b0, evs}, 3'h0);
        max_lp = 1'b1;
        ev(1);
        cv(per, 16'h0100);
        cb({1'b0, evs}, 3'h3);
        cb({2'h0, req}, 3'h0);
        up_down = 1'b1;
        wr(2, 16'h0200);
        wr(4, 16'h0001);
        ev(3);
        cv(per, 16'h0100);
        ev(2);
        cv(per, 16'h0200);
        cb({1'b0, evs}, 3'h3);
        up_down = 1'b0;
        sw_rst = 1'b1;
        wr(2, 16'h0300);
        wr(4, 16'h0001);
        cv(per, 16'h0300);
        cb({2'h0, req}, 3'h0);
        cb({2'h0, rein}, 3'h1);
        sw_rst = 1'b0;
        done("enhanced_sw");
        wr(4, 16'h0001);
        wr(4, 16'h0001, 4'h2);
        cb({2'h0, req}, 3'h1);
        wr(4, 16'h0000);
        cb({2'h0, req}, 3'h0);
        done("request_bit");
        wr(5, 16'h0003);
        shot(3'h1);
        cb(ten, 3'h2);
        {clr_mode, hw_buf} = 2'h3;
        wr(5, 16'h0007);
        wr(2, 16'h0400);
        shot(3'h5);
        cb(ten, 3'h7);
        ev(1);
        cv(per, 16'h0400);
        cb({1'b0, evs}, 3'h3);
        done("hw_trigger");
        {scheme, restart, clr_mode} = 3'h2;
        wr(2, 16'h0500);
        wr(4, 16'h0001);
        cv(per, 16'h0500);
        cb({2'h0, req}, 3'h0);
        {scheme, restart, pair, st_en} = 4'hB;
        wr(0, 16'h6666);
        ev(0);
        cv(chv[0], 16'h5555);
        wr(3, 16'h0010);
        cv(st, 16'h0000);
        wr(4, 16'h0001);
        ev(1);
        cv(chv[0], 16'h6666);
        cv(st, 16'h0010);
        pair = 1'b0;
        mode = PBRS_OC;
        wr(1, 16'h0101);
        cv(chv[1], 16'h7777);
        ev(0);
        cv(chv[1], 16'h0101);
        done("pair_and_start");
        stop_test;
    end
endmodule
